// file: verilog/tmr16_timer.sv
// 16-bit timer with prescaler, external count input and compare event reset
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
// How it works
// - Bit 6 shows system clock from osc
// - Bits 5-4 prescale by 1,2,4,8
// - Bit 3 enables oscillator, else powered off
// - Bit 2 bypasses external input synchroniser
// - Bit 1 selects external pin edges
// - Bit 0 runs timer; bit 7 reads zero
// - Mode 1011 match clears timer, starts conversion
// - Event clear never sets overflow flag
// - Counter write beats simultaneous event clear
// - Compare pair acts as period
// - Counter bytes survive every reset
// - Control cleared to 00h on reset
// - Counter byte write clears prescaler
// - Sixteen-bit counter counts prescaled ticks
// - Overflow sets flag, enabled raises interrupt
module tmr16_timer
#(
  parameter int CNT_W = 16
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       ext_count_pin_i,
  input  wire logic       sysclk_from_osc_i,
  output logic            osc_enable_o,
  output logic            adc_start_o,
  output logic            irq_o
);

  tmr16_pkg::tmr16_bus_type bus;
  logic [7:0]       ctrl_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cmp_r;
  logic [3:0]       mode_r;
  logic [2:0]       pre_r;
  logic [1:0]       stat_r;
  logic [1:0]       en_r;
  logic             ext_sync;
  logic             ext_raw_r;
  logic             ext_prev_r;
  logic             ext_level;
  logic             tick_in;
  logic             tick;
  logic             cnt_wr;
  logic             evt;
  logic             ovf;
  logic             status_bit;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ----------------------------------------------------------------
  // External count input
  // ----------------------------------------------------------------
  tmr16_sync u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (ext_count_pin_i),
    .q_o   (ext_sync)
  );

  // Single sampled copy for the bypass path; still one flop so edges stay clean
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ext_raw_r <= 1'b0;
    else
      ext_raw_r <= ext_count_pin_i;
  end

  // Bypass trades metastability protection for one less stage of delay
  assign ext_level = ctrl_r[tmr16_pkg::TMR16_BIT_SYNC_BYP] ? ext_raw_r : ext_sync;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ext_prev_r <= 1'b0;
    else
      ext_prev_r <= ext_level;
  end

  // Source select: pin rising edge or every system clock as instruction clock
  assign tick_in = ctrl_r[tmr16_pkg::TMR16_BIT_SRC_SEL] ? (ext_level & ~ext_prev_r)
                                                        : 1'b1;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign cnt_wr = bus.wr & ((bus.addr == tmr16_pkg::TMR16_OFF_CNT_LOW) |
                            (bus.addr == tmr16_pkg::TMR16_OFF_CNT_HIGH));

  // Prescaler count cleared by counter writes
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pre_r <= 3'h0;
    else if (cnt_wr)
      pre_r <= 3'h0;
    else if (ctrl_r[tmr16_pkg::TMR16_BIT_RUN_EN] & tick_in)
      pre_r <= pre_r + 3'h1;
  end

  // Terminal count per prescale code
  always_comb
  begin
    unique case (tmr16_pkg::tmr16_pre_type'(ctrl_r[tmr16_pkg::TMR16_BIT_PRE_LO +: 2]))
      tmr16_pkg::TMR16_DIV1: tick = tick_in;
      tmr16_pkg::TMR16_DIV2: tick = tick_in & (pre_r[0] == 1'b1);
      tmr16_pkg::TMR16_DIV4: tick = tick_in & (pre_r[1:0] == 2'h3);
      tmr16_pkg::TMR16_DIV8: tick = tick_in & (pre_r == 3'h7);
    endcase
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Event is a compare match in special mode; period is the compare pair
  assign evt = (mode_r == tmr16_pkg::TMR16_MODE_SPECIAL) & (cnt_r == cmp_r);
  assign ovf = ctrl_r[tmr16_pkg::TMR16_BIT_RUN_EN] & tick & (cnt_r == tmr16_pkg::TMR16_CNT_MAX);

  // No reset branch: contents survive every reset
  always_ff @(posedge clk_i)
  begin
    if (bus.wr & (bus.addr == tmr16_pkg::TMR16_OFF_CNT_LOW))
      cnt_r[7:0] <= bus.wdata;
    else if (bus.wr & (bus.addr == tmr16_pkg::TMR16_OFF_CNT_HIGH))
      cnt_r[15:8] <= bus.wdata;
    else if (evt)
      cnt_r <= '0;
    else if (ctrl_r[tmr16_pkg::TMR16_BIT_RUN_EN] & tick)
      cnt_r <= cnt_r + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_r <= tmr16_pkg::TMR16_CTRL_RESET;
    else if (bus.wr & (bus.addr == tmr16_pkg::TMR16_OFF_CTRL))
      ctrl_r <= bus.wdata & tmr16_pkg::TMR16_CTRL_WMASK;
  end

  // Compare value and mode
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmp_r  <= '0;
      mode_r <= 4'h0;
    end
    else if (bus.wr)
    begin
      if (bus.addr == tmr16_pkg::TMR16_OFF_CMP_LOW)
        cmp_r[7:0] <= bus.wdata;
      if (bus.addr == tmr16_pkg::TMR16_OFF_CMP_HIGH)
        cmp_r[15:8] <= bus.wdata;
      if (bus.addr == tmr16_pkg::TMR16_OFF_CMP_MODE)
        mode_r <= bus.wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky status; a new event beats a same-cycle clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      stat_r <= 2'h0;
    else
    begin
      stat_r[tmr16_pkg::TMR16_IRQ_OVF] <= (ovf & ~cnt_wr & ~evt) |
        (stat_r[tmr16_pkg::TMR16_IRQ_OVF] &
         ~(bus.wr & (bus.addr == tmr16_pkg::TMR16_OFF_IRQ_CLR) & bus.wdata[tmr16_pkg::TMR16_IRQ_OVF]));
      stat_r[tmr16_pkg::TMR16_IRQ_EVT] <= evt |
        (stat_r[tmr16_pkg::TMR16_IRQ_EVT] &
         ~(bus.wr & (bus.addr == tmr16_pkg::TMR16_OFF_IRQ_CLR) & bus.wdata[tmr16_pkg::TMR16_IRQ_EVT]));
    end
  end

  // Enable register
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      en_r <= 2'h0;
    else if (bus.wr & (bus.addr == tmr16_pkg::TMR16_OFF_IRQ_EN))
      en_r <= bus.wdata[1:0] & tmr16_pkg::TMR16_IRQ_MASK;
  end

  assign irq_o = |(stat_r & en_r);

  // ----------------------------------------------------------------
  // Outputs and read path
  // ----------------------------------------------------------------
  // Oscillator inverter powered only while enabled
  assign osc_enable_o = ctrl_r[tmr16_pkg::TMR16_BIT_OSC_EN];

  // Conversion start pulse follows each special event not under a counter write by one cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      adc_start_o <= 1'b0;
    else
      adc_start_o <= evt & ~cnt_wr;
  end

  // Pin status passes the synchroniser; it comes from another domain
  tmr16_sync u_stat_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (sysclk_from_osc_i),
    .q_o   (status_bit)
  );

  // Read data one cycle after strobe; unmapped reads return zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        tmr16_pkg::TMR16_OFF_CTRL:
          rdata_o <= {1'b0, status_bit, ctrl_r[5:0]};
        tmr16_pkg::TMR16_OFF_CNT_LOW:  rdata_o <= cnt_r[7:0];
        tmr16_pkg::TMR16_OFF_CNT_HIGH: rdata_o <= cnt_r[15:8];
        tmr16_pkg::TMR16_OFF_CMP_LOW:  rdata_o <= cmp_r[7:0];
        tmr16_pkg::TMR16_OFF_CMP_HIGH: rdata_o <= cmp_r[15:8];
        tmr16_pkg::TMR16_OFF_CMP_MODE: rdata_o <= {4'h0, mode_r};
        tmr16_pkg::TMR16_OFF_IRQ_STAT: rdata_o <= {6'h00, stat_r};
        tmr16_pkg::TMR16_OFF_IRQ_EN:   rdata_o <= {6'h00, en_r};
        default:                       rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

endmodule : tmr16_timer

// file: verilog/tmr16_pkg.sv
// Package of register map, field positions and reset values for the 16-bit event-reset timer
package tmr16_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR16_OFF_CTRL      = 8'h10;
  localparam logic [7:0] TMR16_OFF_CNT_LOW   = 8'h0E;
  localparam logic [7:0] TMR16_OFF_CNT_HIGH  = 8'h0F;
  localparam logic [7:0] TMR16_OFF_CMP_LOW   = 8'h15;
  localparam logic [7:0] TMR16_OFF_CMP_HIGH  = 8'h16;
  localparam logic [7:0] TMR16_OFF_CMP_MODE  = 8'h17;
  localparam logic [7:0] TMR16_OFF_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] TMR16_OFF_IRQ_EN    = 8'h8C;
  localparam logic [7:0] TMR16_OFF_IRQ_CLR   = 8'h8D;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int TMR16_BIT_RUN_EN     = 0;
  localparam int TMR16_BIT_SRC_SEL    = 1;
  localparam int TMR16_BIT_SYNC_BYP   = 2;
  localparam int TMR16_BIT_OSC_EN     = 3;
  localparam int TMR16_BIT_PRE_LO     = 4;
  localparam int TMR16_BIT_SYSCLK_ST  = 6;
  localparam logic [7:0] TMR16_CTRL_RESET  = 8'h00;
  localparam logic [7:0] TMR16_CTRL_WMASK  = 8'h3F;

  // ----------------------------------------------------------------
  // Interrupt status bits and compare mode
  // ----------------------------------------------------------------
  localparam int TMR16_IRQ_OVF        = 0;
  localparam int TMR16_IRQ_EVT        = 1;
  localparam logic [1:0] TMR16_IRQ_MASK   = 2'h3;
  localparam logic [3:0] TMR16_MODE_SPECIAL = 4'hB;
  localparam logic [15:0] TMR16_CNT_MAX   = 16'hFFFF;

  // Prescale codes
  typedef enum logic [1:0]
  {
    TMR16_DIV1 = 2'h0,
    TMR16_DIV2 = 2'h1,
    TMR16_DIV4 = 2'h2,
    TMR16_DIV8 = 2'h3
  } tmr16_pre_type;

  // Register bus request
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmr16_bus_type;

endpackage : tmr16_pkg

// file: verilog/tmr16_sync.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/1ns
module tmr16_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_r;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : tmr16_sync

// file: testbench/tmr16_checker.sv
// Checker of bus and pin relations of the event-reset timer
`timescale 1ns/1ns
module tmr16_checker
#(
  parameter int CNT_W = 16
)
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       ext_count_pin_i,
  input wire logic       sysclk_from_osc_i,
  input wire logic       osc_enable_o,
  input wire logic       adc_start_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] ctl_r;
  wire logic  rd_ctl = rd_i && addr_i == tmr16_pkg::TMR16_OFF_CTRL;
  wire logic  wr_ctl = wr_i && addr_i == tmr16_pkg::TMR16_OFF_CTRL;
  wire logic  wr_cnt = wr_i && addr_i inside {tmr16_pkg::TMR16_OFF_CNT_LOW, tmr16_pkg::TMR16_OFF_CNT_HIGH};
  wire logic  wr_en0 = wr_i && addr_i == tmr16_pkg::TMR16_OFF_IRQ_EN && wdata_i[1:0] == 2'h0;
  wire logic  unmap  = !(addr_i inside {8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h15, 8'h16, 8'h17, 8'h8C, 8'h8D});

  // Shadow of writable control bits, so read-back is judged by history
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctl_r <= 6'h00;
    else if (wr_ctl)
      ctl_r <= wdata_i[5:0];
  end

  // ----------
  // Properties
  // ----------
  sequence s_osc_steady;
    sysclk_from_osc_i [*4];
  endsequence
  property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  property p_bit7; rd_ctl |=> !rdata_o[7]; endproperty
  property p_sysclk; s_osc_steady ##0 rd_ctl |=> rdata_o[6]; endproperty
  property p_osc_set; wr_ctl ##1 !wr_ctl |=> osc_enable_o == $past(wdata_i[3], 2); endproperty
  property p_osc_hold; !wr_ctl [*2] |=> $stable(osc_enable_o); endproperty
  property p_ctl_rb; rd_ctl |=> rdata_o[5:0] == ctl_r; endproperty
  property p_mask; wr_en0 |=> !irq_o; endproperty
  property p_wr_evt; wr_cnt |=> !adc_start_o; endproperty
  property p_unmap; rd_i && unmap |=> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_bit7: assert property (p_bit7) else $error("control bit 7 not zero");
  a_sysclk: assert property (p_sysclk) else $error("clock status bit low");
  a_osc_set: assert property (p_osc_set) else $error("oscillator enable wrong");
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator enable moved");
  a_ctl_rb: assert property (p_ctl_rb) else $error("control read-back wrong");
  a_mask: assert property (p_mask) else $error("masked interrupt still high");
  a_wr_evt: assert property (p_wr_evt) else $error("event fired under a write");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : tmr16_checker

// file: testbench/tmr16_ext_osc.sv
// Model of the external count oscillator
`timescale 1ns/1ns
module tmr16_ext_osc
#(
  parameter int HALF_NS = 370
)
(
  input  wire logic       osc_en_i,
  input  wire logic       go_i,
  input  wire logic [7:0] n_edges_i,
  output logic            pin_o,
  output logic            busy_o
);
  // Burst of edges on request; pin rests low, and is dead while unpowered
  initial
  begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      @(posedge go_i);
      busy_o = 1'b1;
      repeat (n_edges_i)
      begin
        #HALF_NS pin_o = osc_en_i;
        #HALF_NS pin_o = 1'b0;
      end
      busy_o = 1'b0;
    end
  end
endmodule : tmr16_ext_osc

// file: testbench/tmr16_timer_test.sv
// Self-checking bench of the event-reset timer
`timescale 1ns/1ns
module tmr16_timer_test;
  localparam logic [7:0] CTL = tmr16_pkg::TMR16_OFF_CTRL;
  localparam logic [7:0] LO  = tmr16_pkg::TMR16_OFF_CNT_LOW;
  localparam logic [7:0] HI  = tmr16_pkg::TMR16_OFF_CNT_HIGH;
  localparam logic [7:0] ST  = tmr16_pkg::TMR16_OFF_IRQ_STAT;
  localparam logic [7:0] EN  = tmr16_pkg::TMR16_OFF_IRQ_EN;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       sysclk_from_osc_i = 1'b0;
  logic       go = 1'b0;
  logic [7:0] rdata_o;
  logic       ext_count_pin_i, osc_enable_o, adc_start_o, irq_o, busy;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         k, t;

  tmr16_timer #(.CNT_W(16)) u_tmr16_timer (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .ext_count_pin_i, .sysclk_from_osc_i, .osc_enable_o, .adc_start_o, .irq_o);
  tmr16_ext_osc u_tmr16_ext_osc (.osc_en_i(osc_enable_o), .go_i(go), .n_edges_i(8'h0A),
    .pin_o(ext_count_pin_i), .busy_o(busy));

  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // ----------
  // Bus tasks
  // ----------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk(rdata_o, exp);
  endtask : rd
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Bounded wait for a conversion pulse; n is cycles waited
  task automatic wait_adc(output int n);
    for (n = 1; n <= 40; n++)
    begin
      @(posedge clk_i) #1;
      if (adc_start_o === 1'b1)
        return;
    end
    error_cnt++;
    test_done();
  endtask : wait_adc

  // ----------
  // Tests
  // ----------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(CTL, 8'h00);
    wr(CTL, 8'hFF);
    rd(CTL, 8'h3F);
    chk({7'h00, osc_enable_o}, 8'h01);
    sysclk_from_osc_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(CTL, 8'h7F);
    sysclk_from_osc_i <= 1'b0;
    wr(8'h55, 8'hA5);
    rd(8'h55, 8'h00);
    $display("registers done");
    // Each prescale code over a 68-cycle window; odd codes set the ignored bypass bit
    for (k = 0; k < 4; k++)
    begin
      wr(HI, 8'h00);
      wr(CTL, 8'(k * 16 + (k % 2) * 4 + 1));
      wr(LO, 8'h00);
      repeat (66) @(posedge clk_i);
      wr(CTL, 8'(k * 16));
      rd(LO, 8'(68 >> k));
    end
    wr(CTL, 8'h08);
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    rd(LO, 8'h08);
    rd(CTL, 8'h00);
    $display("prescale and reset done");
    // Pin edges, synchronised then unsynchronised
    for (k = 0; k < 2; k++)
    begin
      wr(CTL, 8'(8'h0B + k * 4));
      wr(LO, 8'h00);
      go <= 1'b1;
      @(posedge clk_i) go <= 1'b0;
      for (t = 0; busy && t < 100; t++)
        @(posedge clk_i);
      if (busy)
      begin
        error_cnt++;
        test_done();
      end
      repeat (6) @(posedge clk_i);
      rd(LO, 8'h0A);
    end
    $display("external pin done");
    // Wrap raises the flag and the level interrupt; then mask and clear
    wr(tmr16_pkg::TMR16_OFF_IRQ_CLR, 8'h03);
    wr(EN, 8'h01);
    wr(HI, 8'hFF);
    wr(LO, 8'hFE);
    wr(CTL, 8'h01);
    repeat (4) @(posedge clk_i);
    wr(CTL, 8'h00);
    rd(ST, 8'h01);
    rd(HI, 8'h00);
    chk({7'h00, irq_o}, 8'h01);
    wr(EN, 8'h00);
    #1 chk({7'h00, irq_o}, 8'h00);
    wr(EN, 8'h01);
    wr(tmr16_pkg::TMR16_OFF_IRQ_CLR, 8'h01);
    rd(ST, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    $display("overflow done");
    // Event mode: compare pair sets the period, no overflow flag, write wins
    wr(tmr16_pkg::TMR16_OFF_CMP_LOW, 8'h10);
    wr(tmr16_pkg::TMR16_OFF_CMP_HIGH, 8'h00);
    wr(tmr16_pkg::TMR16_OFF_CMP_MODE, 8'h0B);
    wr(LO, 8'h00);
    wr(CTL, 8'h01);
    wait_adc(t);
    wait_adc(t);
    chk(8'(t), 8'h11);
    wr(CTL, 8'h00);
    rd(ST, 8'h02);
    bus(1'b1, 1'b0, LO, 8'h10);
    bus(1'b1, 1'b0, LO, 8'h33);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    rd(LO, 8'h33);
    // High byte preload leaves the low byte untouched
    wr(HI, 8'h80);
    rd(LO, 8'h33);
    rd(HI, 8'h80);
    $display("event done");
    test_done();
  end
endmodule : tmr16_timer_test

bind tmr16_timer tmr16_checker #(.CNT_W(CNT_W)) u_tmr16_checker (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .ext_count_pin_i, .sysclk_from_osc_i, .osc_enable_o, .adc_start_o, .irq_o);
